//--- rtl/cssr_map.svh
// Offsets, fields and reset values of the status and stack block.
`ifndef CSSR_MAP_SVH
`define CSSR_MAP_SVH

//------------------------------------------------------------------------
// Register byte offsets on the AXI4-Lite slave
//------------------------------------------------------------------------
`define CSSR_OFF_STATUS      8'h00
`define CSSR_OFF_SPTR        8'h04
`define CSSR_OFF_TOS_LOW     8'h08
`define CSSR_OFF_TOS_HIGH    8'h0c
`define CSSR_OFF_STKERR      8'h10
`define CSSR_OFF_CONFIG      8'h14

//------------------------------------------------------------------------
// Status register fields
//------------------------------------------------------------------------
`define CSSR_BIT_C           0
`define CSSR_BIT_DIG         1
`define CSSR_BIT_Z           2
`define CSSR_BIT_PWR_N       3
`define CSSR_BIT_TO_N        4
`define CSSR_STATUS_RST      8'h18
`define CSSR_ARITH_MASK      8'h07

//------------------------------------------------------------------------
// Stack geometry and reset values
//------------------------------------------------------------------------
`define CSSR_STACK_DEPTH     16
`define CSSR_PC_W            15
`define CSSR_SP_W            5
`define CSSR_SP_RST          5'h1f
`define CSSR_SP_TOP          5'h0f
`define CSSR_CFG_RST         1'h1

//------------------------------------------------------------------------
// AXI response codes
//------------------------------------------------------------------------
`define CSSR_RESP_OKAY       2'h0
`define CSSR_RESP_SLVERR     2'h2

`endif

//--- rtl/cssr_pkg.sv
// Types shared by the core status and return stack block.
package cssr_pkg;

    // ALU operation class reported by the execution core.
    typedef enum logic [2:0] {
        CSSR_OP_NONE  = 3'b000,
        CSSR_OP_LOGIC = 3'b001,
        CSSR_OP_ADD   = 3'b010,
        CSSR_OP_SUB   = 3'b011,
        CSSR_OP_ROR   = 3'b100,
        CSSR_OP_ROL   = 3'b101
    } cssr_op_t;

    // Stack action requested by the execution core.
    typedef enum logic [1:0] {
        CSSR_STK_IDLE = 2'b00,
        CSSR_STK_PUSH = 2'b01,
        CSSR_STK_POP  = 2'b10
    } cssr_stk_t;

    // Write channel state of the bus slave.
    typedef enum logic [1:0] {
        CSSR_WR_IDLE = 2'b00,
        CSSR_WR_RESP = 2'b01
    } cssr_wst_t;

endpackage

//--- rtl/cssr_alu_if.sv
// Interface carrying ALU operands and flag results between the two modules.
`timescale 1ns/1ps
`default_nettype none

interface cssr_alu_if;
    import cssr_pkg::*;
    cssr_op_t   op;
    logic [7:0] a;
    logic [7:0] b;
    logic [7:0] result;
    logic       z;
    logic       dig;
    logic       c;
    logic       upd_z;
    logic       upd_dig;
    logic       upd_c;

    modport core (output op, output a, output b,
                  input result, input z, input dig, input c,
                  input upd_z, input upd_dig, input upd_c);
    modport alu  (input op, input a, input b,
                  output result, output z, output dig, output c,
                  output upd_z, output upd_dig, output upd_c);
endinterface

`default_nettype wire

//--- rtl/cssr_alu.sv
// Combinational ALU that produces result and arithmetic flags.
`timescale 1ns/1ps
`default_nettype none

module cssr_alu
    import cssr_pkg::*;
(
    // Operands and flags.
    cssr_alu_if.alu alu,
    // Carry input for rotates.
    input wire logic c_in
);

    logic [8:0] sum;
    logic [4:0] nib;
    logic [7:0] opb;

    //--------------------------------------------------------------------
    // Arithmetic
    //--------------------------------------------------------------------
    // two's complement subtract: borrow shows as carry clear.
    always_comb begin
        opb = (alu.op == CSSR_OP_SUB) ? (~alu.b) : alu.b;
        sum = {1'b0, alu.a} + {1'b0, opb} + {8'h00, (alu.op == CSSR_OP_SUB)};
        nib = {1'b0, alu.a[3:0]} + {1'b0, opb[3:0]} + {4'h0, (alu.op == CSSR_OP_SUB)};
    end

    // Result, flag values and which flags the operation touches.
    always_comb begin
        alu.result = 8'h00;
        alu.c      = c_in;
        alu.dig     = 1'b0;
        alu.upd_z   = 1'b0;
        alu.upd_dig = 1'b0;
        alu.upd_c  = 1'b0;
        case (alu.op)
            CSSR_OP_LOGIC: begin
                alu.result = alu.a;
                alu.upd_z  = 1'b1;
            end
            CSSR_OP_ADD, CSSR_OP_SUB: begin
                alu.result = sum[7:0];
                alu.dig     = nib[4];
                alu.c      = sum[8];
                alu.upd_z   = 1'b1;
                alu.upd_dig = 1'b1;
                alu.upd_c  = 1'b1;
            end
            CSSR_OP_ROR: begin
                alu.result = {c_in, alu.a[7:1]};
                alu.c      = alu.a[0];
                alu.upd_c  = 1'b1;
            end
            CSSR_OP_ROL: begin
                alu.result = {alu.a[6:0], c_in};
                alu.c      = alu.a[7];
                alu.upd_c  = 1'b1;
            end
            default: begin
                alu.result = alu.a;
            end
        endcase
        alu.z = (alu.result == 8'h00);
    end

endmodule

`default_nettype wire

//--- rtl/cssr_core.sv
// Core status flags and sixteen-entry return stack with AXI4-Lite access.
// Operation
// - Arithmetic flags override status writes.
// - Timeout flag: clear/sleep set, timeout clears.
// - Powerdown flag: clear sets, sleep clears.
// - Zero flag marks zero result.
// - Add/subtract digit carry from nibble.
// - Add/subtract carry from top bit.
// - Subtract adds complement; carry means no borrow.
// - Rotates load carry with shifted bit.
// - Upper three status bits read zero.
// - Sixteen fifteen-bit entries, separate storage.
// - Calls and interrupts push, returns pop.
// - Stack actions leave pc upper latch.
// - Circular stack when overflow reset off.
// - Error flags set regardless of enable.
// - Top-of-stack pair reads entry at pointer.
// - Stack pointer is five bits.
// - Push increments then writes; pop reads first.
`timescale 1ns/1ps
`default_nettype none
`include "cssr_map.svh"

module cssr_core
    import cssr_pkg::*;
(
    // Clock and reset.
    input  wire logic        CLK,
    input  wire logic        RST,
    // Execution core: ALU operation, one cycle per instruction.
    input  wire logic        EXE_VALID,
    input  wire logic [2:0]  EXE_OP,
    input  wire logic [7:0]  EXE_A,
    input  wire logic [7:0]  EXE_B,
    input  wire logic        EXE_DEST_STATUS,
    input  wire logic [7:0]  EXE_WDATA,
    output logic      [7:0]  EXE_RESULT,
    // Execution core: reset cause events, one-cycle pulses.
    input  wire logic        EVT_WD_CLEAR,
    input  wire logic        EVT_SLEEP,
    input  wire logic        EVT_WD_TIMEOUT,
    // Execution core: stack actions.
    input  wire logic [1:0]  STK_CMD,
    input  wire logic [14:0] STK_PC_IN,
    output logic      [14:0] STK_PC_OUT,
    // Status register and stack error view.
    output logic      [7:0]  STATUS_OUT,
    output logic             STK_RESET_REQ,
    // AXI4-Lite slave.
    input  wire logic [7:0]  S_AWADDR,
    input  wire logic        S_AWVALID,
    output logic             S_AWREADY,
    input  wire logic [31:0] S_WDATA,
    input  wire logic [3:0]  S_WSTRB,
    input  wire logic        S_WVALID,
    output logic             S_WREADY,
    output logic      [1:0]  S_BRESP,
    output logic             S_BVALID,
    input  wire logic        S_BREADY,
    input  wire logic [7:0]  S_ARADDR,
    input  wire logic        S_ARVALID,
    output logic             S_ARREADY,
    output logic      [31:0] S_RDATA,
    output logic      [1:0]  S_RRESP,
    output logic             S_RVALID,
    input  wire logic        S_RREADY
);

    //--------------------------------------------------------------------
    // Declarations
    //--------------------------------------------------------------------
    cssr_alu_if  alu_bus ();
    cssr_stk_t   stk_cmd;
    cssr_wst_t   wst_r;
    logic [7:0]  status_r;
    logic [4:0]  sp_r;
    logic        ovf_r;
    logic        unf_r;
    logic        ovren_r;
    logic [14:0] stack_mem [`CSSR_STACK_DEPTH];
    logic [7:0]  awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0]  wstrb_r;
    logic        aw_got_r;
    logic        w_got_r;
    logic        wr_go;
    logic        wr_hit;
    logic [3:0]  sp_idx;
    logic [4:0]  sp_inc;
    logic [4:0]  sp_dec;
    logic        do_push;
    logic        do_pop;
    logic        push_ovf;
    logic        pop_unf;
    logic [14:0] tos_val;
    logic [31:0] rd_word;
    logic        rd_hit;

    //--------------------------------------------------------------------
    // ALU
    //--------------------------------------------------------------------
    assign alu_bus.op = EXE_VALID ? cssr_op_t'(EXE_OP) : CSSR_OP_NONE;
    assign alu_bus.a  = EXE_A;
    assign alu_bus.b  = EXE_B;
    assign EXE_RESULT = alu_bus.result;

    cssr_alu u_alu (
        .alu  (alu_bus),
        .c_in (status_r[`CSSR_BIT_C])
    );

    //--------------------------------------------------------------------
    // AXI write channel
    //--------------------------------------------------------------------
    // Address and data are accepted in either order and held until both arrive.
    assign S_AWREADY = (wst_r == CSSR_WR_IDLE) && !aw_got_r;
    assign S_WREADY  = (wst_r == CSSR_WR_IDLE) && !w_got_r;
    assign wr_go     = (wst_r == CSSR_WR_IDLE) && aw_got_r && w_got_r;
    assign S_BRESP   = `CSSR_RESP_OKAY;
    assign S_BVALID  = (wst_r == CSSR_WR_RESP);

    // Capture of the write address.
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            aw_got_r <= 1'b0;
            awaddr_r <= 8'h00;
        end else if (S_AWVALID && S_AWREADY) begin
            aw_got_r <= 1'b1;
            awaddr_r <= S_AWADDR;
        end else if (wr_go) begin
            aw_got_r <= 1'b0;
        end
    end

    // Capture of the write data.
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            w_got_r <= 1'b0;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
        end else if (S_WVALID && S_WREADY) begin
            w_got_r <= 1'b1;
            wdata_r <= S_WDATA;
            wstrb_r <= S_WSTRB;
        end else if (wr_go) begin
            w_got_r <= 1'b0;
        end
    end

    // Response state machine.
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            wst_r <= CSSR_WR_IDLE;
        end else begin
            case (wst_r)
                CSSR_WR_IDLE: begin
                    if (wr_go) begin
                        wst_r <= CSSR_WR_RESP;
                    end
                end
                CSSR_WR_RESP: begin
                    if (S_BREADY) begin
                        wst_r <= CSSR_WR_IDLE;
                    end
                end
                default: begin
                    wst_r <= CSSR_WR_IDLE;
                end
            endcase
        end
    end

    // Unmapped writes are silently dropped with OKAY; only byte lane 0 matters.
    assign wr_hit = wr_go && wstrb_r[0];

    //--------------------------------------------------------------------
    // Stack control
    //--------------------------------------------------------------------
    // Pointer arithmetic wraps at five bits; the decode below reads the wrap.
    assign stk_cmd  = cssr_stk_t'(STK_CMD);
    assign sp_inc   = sp_r + 5'h01;
    assign sp_dec   = sp_r - 5'h01;
    // push on call, pop on return.
    assign do_push  = (stk_cmd == CSSR_STK_PUSH);
    assign do_pop   = (stk_cmd == CSSR_STK_POP);
    assign push_ovf = do_push && (sp_r == `CSSR_SP_TOP);
    assign pop_unf  = do_pop && (sp_r == 5'h00 || sp_r == `CSSR_SP_RST);
    // circular index uses the low four bits.
    assign sp_idx   = sp_r[3:0];
    // top of stack follows the pointer.
    assign tos_val  = stack_mem[sp_idx];
    assign STK_PC_OUT = tos_val;
    // The request is a level; the core decides when to act on it.
    assign STK_RESET_REQ = ovren_r && (ovf_r || unf_r);

    // Stack pointer.
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            sp_r <= `CSSR_SP_RST;
        end else if (do_push) begin
            // wrap to entry zero after sixteen pushes.
            sp_r <= (push_ovf && !ovren_r) ? 5'h10 : sp_inc;
        end else if (do_pop) begin
            sp_r <= sp_dec;
        end else if (wr_hit && awaddr_r == `CSSR_OFF_SPTR) begin
            sp_r <= wdata_r[4:0];
        end
    end

    // separate sixteen by fifteen storage; no latch touched here.
    always_ff @(posedge CLK) begin
        if (do_push) begin
            stack_mem[sp_inc[3:0]] <= STK_PC_IN;
        end else if (wr_hit && awaddr_r == `CSSR_OFF_TOS_LOW) begin
            stack_mem[sp_idx] <= {tos_val[14:8], wdata_r[7:0]};
        end else if (wr_hit && awaddr_r == `CSSR_OFF_TOS_HIGH) begin
            stack_mem[sp_idx] <= {wdata_r[6:0], tos_val[7:0]};
        end
    end

    // error flags set regardless of reset enable.
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            ovf_r <= 1'b0;
            unf_r <= 1'b0;
        end else begin
            // Set beats a simultaneous software clear.
            ovf_r <= push_ovf || (ovf_r &&
                     !(wr_hit && awaddr_r == `CSSR_OFF_STKERR && !wdata_r[0]));
            unf_r <= pop_unf || (unf_r &&
                     !(wr_hit && awaddr_r == `CSSR_OFF_STKERR && !wdata_r[1]));
        end
    end

    // Overflow reset enable, a configuration bit held here.
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            ovren_r <= `CSSR_CFG_RST;
        end else if (wr_hit && awaddr_r == `CSSR_OFF_CONFIG) begin
            ovren_r <= wdata_r[0];
        end
    end

    //--------------------------------------------------------------------
    // Status register
    //--------------------------------------------------------------------
    // The core writes status directly; the bus path is secondary.
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            status_r <= `CSSR_STATUS_RST;
        end else begin
            // Plain writes reach only the arithmetic bits.
            if (EXE_VALID && EXE_DEST_STATUS) begin
                // flags touched by the op are masked.
                status_r[`CSSR_BIT_C]  <= EXE_WDATA[`CSSR_BIT_C];
                status_r[`CSSR_BIT_DIG] <= EXE_WDATA[`CSSR_BIT_DIG];
                status_r[`CSSR_BIT_Z]  <= EXE_WDATA[`CSSR_BIT_Z];
            end else if (wr_hit && awaddr_r == `CSSR_OFF_STATUS) begin
                status_r[2:0] <= wdata_r[2:0];
            end
            // flags commit with the destination write.
            if (alu_bus.upd_z) begin
                status_r[`CSSR_BIT_Z] <= alu_bus.z;
            end
            if (alu_bus.upd_dig) begin
                status_r[`CSSR_BIT_DIG] <= alu_bus.dig;
            end
            if (alu_bus.upd_c) begin
                status_r[`CSSR_BIT_C] <= alu_bus.c;
            end
            // timeout flag; timeout wins over clear.
            if (EVT_WD_TIMEOUT) begin
                status_r[`CSSR_BIT_TO_N] <= 1'b0;
            end else if (EVT_WD_CLEAR || EVT_SLEEP) begin
                status_r[`CSSR_BIT_TO_N] <= 1'b1;
            end
            if (EVT_SLEEP) begin
                status_r[`CSSR_BIT_PWR_N] <= 1'b0;
            end else if (EVT_WD_CLEAR) begin
                status_r[`CSSR_BIT_PWR_N] <= 1'b1;
            end
            status_r[7:5] <= 3'h0;
        end
    end
    assign STATUS_OUT = status_r;

    //--------------------------------------------------------------------
    // AXI read channel
    //--------------------------------------------------------------------
    // Read mux; narrow registers sit in the low bits.
    always_comb begin
        rd_hit  = 1'b1;
        rd_word = 32'h0000_0000;
        case (S_ARADDR)
            `CSSR_OFF_STATUS:   rd_word = {24'h000000, status_r};
            `CSSR_OFF_SPTR:     rd_word = {27'h0000000, sp_r};
            `CSSR_OFF_TOS_LOW:  rd_word = {24'h000000, tos_val[7:0]};
            `CSSR_OFF_TOS_HIGH: rd_word = {25'h0000000, tos_val[14:8]};
            `CSSR_OFF_STKERR:   rd_word = {30'h00000000, unf_r, ovf_r};
            `CSSR_OFF_CONFIG:   rd_word = {31'h00000000, ovren_r};
            default:            rd_hit  = 1'b0;
        endcase
    end

    // One read in flight; a new address waits until the answer is taken.
    assign S_ARREADY = !S_RVALID;

    // One-cycle read answer, held until taken.
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            S_RVALID <= 1'b0;
            S_RDATA  <= 32'h0000_0000;
            S_RRESP  <= `CSSR_RESP_OKAY;
        end else if (S_ARVALID && S_ARREADY) begin
            S_RVALID <= 1'b1;
            S_RDATA  <= rd_word;
            S_RRESP  <= rd_hit ? `CSSR_RESP_OKAY : `CSSR_RESP_SLVERR;
        end else if (S_RREADY) begin
            S_RVALID <= 1'b0;
        end
    end

endmodule

`default_nettype wire

//--- verif/cssr_core_props.sv
// Concurrent checks on the status flags and return stack ports.
`timescale 1ns/1ps
`default_nettype none

module cssr_core_props (
    // Clock and reset.
    input wire logic        CLK,
    input wire logic        RST,
    // Execution core side.
    input wire logic        EXE_VALID,
    input wire logic [2:0]  EXE_OP,
    input wire logic [7:0]  EXE_A,
    input wire logic [7:0]  EXE_B,
    input wire logic [7:0]  EXE_RESULT,
    input wire logic        EVT_WD_CLEAR,
    input wire logic        EVT_SLEEP,
    input wire logic        EVT_WD_TIMEOUT,
    input wire logic [1:0]  STK_CMD,
    input wire logic [14:0] STK_PC_IN,
    input wire logic [14:0] STK_PC_OUT,
    // Status view.
    input wire logic [7:0]  STATUS_OUT
);
    // ------------
    // Flag helpers
    // ------------
    logic [1:0] add_c_w;
    logic [1:0] sub_c_w;
    logic       zero_w;
    logic       rot_w;

    // Flags worked out apart from the ALU; set carry means no borrow.
    assign add_c_w = {EXE_A[3:0] > ~EXE_B[3:0], EXE_A > ~EXE_B};
    assign sub_c_w = {EXE_A[3:0] >= EXE_B[3:0], EXE_A >= EXE_B};
    assign zero_w  = (EXE_RESULT == 8'h0);
    assign rot_w   = EXE_OP[0] ? EXE_A[7] : EXE_A[0];

    default clocking @(posedge CLK); endclocking
    default disable iff (RST);

    // ----------
    // Properties
    // ----------
    chk_upper_zero: assert property (STATUS_OUT[7:5] == 3'h0)
        else $error("status upper bits set");
    chk_timeout_clr: assert property (EVT_WD_TIMEOUT |=> !STATUS_OUT[4])
        else $error("timeout flag not cleared");
    chk_sleep_pd: assert property (EVT_SLEEP |=> !STATUS_OUT[3])
        else $error("powerdown flag not cleared");
    chk_watchdog_clear_instr_set: assert property (
        EVT_WD_CLEAR && !EVT_SLEEP && !EVT_WD_TIMEOUT |=> STATUS_OUT[4:3] == 2'h3)
        else $error("clear did not set both flags");
    chk_zero_flag: assert property (
        EXE_VALID && EXE_OP inside {3'h1, 3'h2, 3'h3} |=> STATUS_OUT[2] == $past(zero_w))
        else $error("zero flag wrong");
    chk_add_carry: assert property (
        EXE_VALID && EXE_OP == 3'h2 |=> STATUS_OUT[1:0] == $past(add_c_w))
        else $error("add carries wrong");
    chk_sub_borrow: assert property (
        EXE_VALID && EXE_OP == 3'h3 |=> STATUS_OUT[1:0] == $past(sub_c_w))
        else $error("subtract borrows wrong");
    chk_sub_result: assert property (
        EXE_VALID && EXE_OP == 3'h3 |-> EXE_RESULT == EXE_A - EXE_B)
        else $error("subtract result wrong");
    chk_rotate_c: assert property (
        EXE_VALID && EXE_OP[2:1] == 2'h2 |=> STATUS_OUT[0] == $past(rot_w))
        else $error("rotate carry wrong");
    chk_push_top: assert property (
        STK_CMD == 2'h1 |=> STK_PC_OUT == $past(STK_PC_IN))
        else $error("pushed value not on top");
endmodule

bind cssr_core cssr_core_props cssr_core_props_i (.*);

`default_nettype wire

//--- verif/cssr_exec_model.sv
// Behavioural execution core: instructions, events, stack actions.
`timescale 1ns/1ps
`default_nettype none

module cssr_exec_model (
    // Clock.
    input  wire logic   clk,
    // Instruction lines.
    output logic        exe_valid,
    output logic [2:0]  exe_op,
    output logic [7:0]  exe_a,
    output logic [7:0]  exe_b,
    output logic        exe_dst,
    output logic [7:0]  exe_wd,
    // Reset cause pulses.
    output logic        ev_clr,
    output logic        ev_sleep,
    output logic        ev_tmo,
    // Stack actions.
    output logic [1:0]  stk_cmd,
    output logic [14:0] stk_pc
);
    // Quiet lines from time zero.
    initial {exe_valid, exe_op, exe_a, exe_b, exe_dst, exe_wd, ev_clr, ev_sleep, ev_tmo, stk_cmd,
             stk_pc} = '0;

    // One instruction; released operands flip so stale data shows.
    task automatic instr(input logic [2:0] op, input logic [7:0] a, input logic [7:0] b,
                         input logic dst, input logic [7:0] wd);
        @(posedge clk);
        exe_valid <= 1'b1;
        exe_op    <= op;
        exe_a     <= a;
        exe_b     <= b;
        exe_dst   <= dst;
        exe_wd    <= wd;
        @(posedge clk);
        exe_valid <= 1'b0;
        exe_op    <= 3'h0;
        exe_a     <= ~a;
        exe_b     <= ~b;
        exe_dst   <= 1'b0;
        exe_wd    <= ~wd;
    endtask

    // One-cycle event: 0 clear, 1 sleep, 2 time-out.
    task automatic evt(input int k);
        @(posedge clk);
        {ev_tmo, ev_sleep, ev_clr} <= 3'(1 << k);
        @(posedge clk);
        {ev_tmo, ev_sleep, ev_clr} <= 3'h0;
    endtask

    task automatic stk(input logic [1:0] cmd, input logic [14:0] pc);
        @(posedge clk);
        stk_cmd <= cmd;
        stk_pc  <= pc;
        @(posedge clk);
        stk_cmd <= 2'h0;
        stk_pc  <= ~pc;
    endtask
endmodule

`default_nettype wire

//--- verif/cssr_core_tb.sv
// Self-checking bench for the status flags and return stack block.
`timescale 1ns/1ps
`default_nettype none

module cssr_core_tb;
    logic        clk, rst, exe_valid, exe_dst, ev_clr, ev_sleep, ev_tmo, rst_req;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    logic [1:0]  stk_cmd, bresp, rresp, r;
    logic [2:0]  exe_op, op, old;
    logic [3:0]  wstrb;
    logic [7:0]  exe_a, exe_b, exe_wd, result, status, awaddr, araddr, a, b;
    logic [14:0] stk_pc, pc_out;
    logic [31:0] wdata, rdata, tmp, d;
    logic [14:0] pcs [17];
    int          fails, n_checks, i;
    integer      seed;
    logic [18:0] corner [4] = '{{3'h2, 8'h08, 8'h08}, {3'h3, 8'h10, 8'h01},
                                {3'h2, 8'hff, 8'h01}, {3'h3, 8'h05, 8'h05}};
    int          ev_k [5] = '{2, 0, 1, 2, 0};
    logic [1:0]  ev_x [5] = '{2'h1, 2'h3, 2'h2, 2'h0, 2'h3};

    cssr_core cssr_core_i (
        .CLK(clk), .RST(rst), .EXE_VALID(exe_valid), .EXE_OP(exe_op), .EXE_A(exe_a),
        .EXE_B(exe_b), .EXE_DEST_STATUS(exe_dst), .EXE_WDATA(exe_wd), .EXE_RESULT(result),
        .EVT_WD_CLEAR(ev_clr), .EVT_SLEEP(ev_sleep), .EVT_WD_TIMEOUT(ev_tmo),
        .STK_CMD(stk_cmd), .STK_PC_IN(stk_pc), .STK_PC_OUT(pc_out), .STATUS_OUT(status),
        .STK_RESET_REQ(rst_req), .S_AWADDR(awaddr), .S_AWVALID(awvalid),
        .S_AWREADY(awready), .S_WDATA(wdata), .S_WSTRB(wstrb), .S_WVALID(wvalid),
        .S_WREADY(wready), .S_BRESP(bresp), .S_BVALID(bvalid), .S_BREADY(bready),
        .S_ARADDR(araddr), .S_ARVALID(arvalid), .S_ARREADY(arready), .S_RDATA(rdata),
        .S_RRESP(rresp), .S_RVALID(rvalid), .S_RREADY(rready));
    cssr_exec_model cssr_exec_model_i (
        .clk, .exe_valid, .exe_op, .exe_a, .exe_b, .exe_dst, .exe_wd, .ev_clr,
        .ev_sleep, .ev_tmo, .stk_cmd, .stk_pc);

    // Half period of the 50 ns clock.
    always #25 clk = ~clk;

    // -------------
    // Bench helpers
    // -------------
    task automatic close_out;
        $display("Checks %0d, mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic give_up;
        fails++;
        $display("[ERR] %0t bus wait timed out", $time);
        close_out;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Write channels are released one by one as each is taken.
    task automatic axi_wr(input logic [7:0] ad, input logic [31:0] dv);
        int n;
        @(posedge clk);
        awaddr  <= ad;
        awvalid <= 1'b1;
        wdata   <= dv;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        bready <= 1'b0;
        if (n == 40) give_up;
    endtask

    // Read data and response land in d and r.
    task automatic axi_rd(input logic [7:0] ad);
        int n;
        @(posedge clk);
        araddr  <= ad;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        if (n == 40) give_up;
    endtask

    // Expected zero, digit and carry flags; pre holds them before the operation.
    function automatic logic [2:0] exp_flags(input logic [2:0] o, input logic [7:0] x,
                                             input logic [7:0] y, input logic [2:0] pre);
        case (o)
            3'h1: exp_flags = {x == 8'h0, pre[1:0]};
            3'h2: exp_flags = {8'(x + y) == 8'h0, x[3:0] > ~y[3:0], x > ~y};
            3'h3: exp_flags = {x == y, x[3:0] >= y[3:0], x >= y};
            3'h4: exp_flags = {pre[2:1], x[0]};
            default: exp_flags = {pre[2:1], x[7]};
        endcase
    endfunction

    // ---------------
    // Main sequence
    // ---------------
    initial begin
        clk      = 1'b0;
        rst      = 1'b1;
        {awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready} = '0;
        wstrb    = 4'hf;
        fails    = 0;
        n_checks = 0;
        seed     = 32'h4ed2;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        axi_rd(8'h00);
        chk(d, 32'h18);
        axi_rd(8'h04);
        chk(d, 32'h1f);
        axi_rd(8'h1c);
        chk(r, 2'h2);
        axi_wr(8'h00, 32'hff);
        axi_rd(8'h00);
        chk(d, 32'h1f);
        old = 3'h7;
        // Corner adds and subtracts, then random ops, some onto the status register.
        for (i = 0; i < 44; i++) begin
            tmp = $random(seed);
            {op, a, b} = (i < 4) ? corner[i]
                                 : {3'h1 + tmp[2:0] % 3'h5, tmp[15:8], tmp[23:16]};
            cssr_exec_model_i.instr(op, a, b, tmp[24], tmp[31:24]);
            @(negedge clk);
            old = exp_flags(op, a, b, tmp[24] ? tmp[26:24] : old);
            chk(status[2:0], old);
        end
        for (i = 0; i < 5; i++) begin
            cssr_exec_model_i.evt(ev_k[i]);
            @(negedge clk);
            chk(status[4:3], ev_x[i]);
        end
        // Fill sixteen entries, then unwind them.
        for (i = 0; i < 17; i++) begin
            tmp = $random(seed);
            pcs[i] = tmp[14:0];
        end
        for (i = 0; i < 16; i++) cssr_exec_model_i.stk(2'h1, pcs[i]);
        axi_rd(8'h04);
        chk(d, 32'h0f);
        for (i = 15; i >= 0; i--) begin
            @(negedge clk);
            chk(pc_out, pcs[i]);
            cssr_exec_model_i.stk(2'h2, 15'h0);
        end
        // Circular: push seventeen lands on entry zero.
        axi_wr(8'h10, 32'h0);
        axi_wr(8'h14, 32'h0);
        for (i = 0; i < 17; i++) cssr_exec_model_i.stk(2'h1, pcs[i]);
        @(negedge clk);
        chk(pc_out, pcs[16]);
        chk(rst_req, 1'b0);
        axi_rd(8'h10);
        chk(d[0], 1'b1);
        axi_wr(8'h04, 32'h05);
        axi_rd(8'h08);
        chk(d, {24'h0, pcs[5][7:0]});
        axi_rd(8'h0c);
        chk(d, {25'h0, pcs[5][14:8]});
        axi_wr(8'h08, 32'h3c);
        @(negedge clk);
        chk(pc_out[7:0], 8'h3c);
        // A return from an empty stack.
        axi_wr(8'h04, 32'h1f);
        cssr_exec_model_i.stk(2'h2, 15'h0);
        axi_rd(8'h10);
        chk(d[1], 1'b1);
        axi_wr(8'h14, 32'h1);
        @(negedge clk);
        chk(rst_req, 1'b1);
        close_out;
    end
endmodule

`default_nettype wire
